/* rtl/door_io_pkg.sv */
package door_io_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] REG_RELAY_CFG0 = 8'h00;
	localparam logic [7:0] REG_RELAY_CFG1 = 8'h04;
	localparam logic [7:0] REG_RELAY_CFG2 = 8'h08;
	localparam logic [7:0] REG_INPUT_CFG  = 8'h0C;
	localparam logic [7:0] REG_CONTROL    = 8'h10;
	localparam logic [7:0] REG_PULSE_LEN  = 8'h14;
	localparam logic [7:0] REG_STATUS     = 8'h18;
	localparam logic [7:0] REG_LOCK_DELAY = 8'h1C;

	// ==========================================================
	// Relay configuration word fields
	localparam int FUNC_LSB  = 0;
	localparam int SEL_LSB   = 4;
	localparam int BEHAV_LSB = 8;
	localparam int NUM_RELAY = 3;
	localparam int NUM_INPUT = 3;

	// ==========================================================
	// Relay function codes
	localparam logic [3:0] RF_OFF   = 4'h1;
	localparam logic [3:0] RF_END   = 4'h3;
	localparam logic [3:0] RF_LOCK  = 4'h4;
	localparam logic [3:0] RF_RADIO = 4'h5;
	localparam logic [3:0] RF_FAULT = 4'h6;
	localparam logic [3:0] RF_BRAKE = 4'h7;

	// Endposition selections
	localparam logic [3:0] EP_OPEN       = 4'h1;
	localparam logic [3:0] EP_CLOSED     = 4'h2;
	localparam logic [3:0] EP_BOTH       = 4'h3;
	localparam logic [3:0] EP_NOT_OPEN   = 4'h4;
	localparam logic [3:0] EP_NOT_CLOSED = 4'h5;
	localparam logic [3:0] EP_NOT_ANY    = 4'h6;

	// Behaviour codes
	localparam logic [1:0] BH_PERM   = 2'h1;
	localparam logic [1:0] BH_PULSE  = 2'h2;
	localparam logic [1:0] BH_TOGGLE = 2'h2;

	// Lock modes
	localparam logic [3:0] LK_PERM  = 4'h1;
	localparam logic [3:0] LK_OPEN  = 4'h2;
	localparam logic [3:0] LK_CLOSE = 4'h3;

	// ==========================================================
	// Input function codes
	localparam logic [3:0] IN_IMPULSE = 4'h2;
	localparam logic [3:0] IN_OPEN    = 4'h3;
	localparam logic [3:0] IN_PARTIAL = 4'h4;
	localparam logic [3:0] IN_CLOSE   = 4'h5;
	localparam logic [3:0] IN_STOP    = 4'h6;
	localparam logic [3:0] IN_SMOKE   = 4'h7;
	localparam logic [3:0] IN_LOCKREL = 4'h8;

	// ==========================================================
	// Reset values
	localparam logic [15:0] PULSE_LEN_RST  = 16'h0028;
	localparam logic [15:0] LOCK_DELAY_RST = 16'h0000;
	localparam logic [31:0] RELAY_CFG_RST  = 32'h0000_0001;
	localparam logic [31:0] INPUT_CFG_RST  = 32'h0000_0653;

endpackage

/* rtl/relay_pulse.sv */
`timescale 1ns/1ps

// ==========================================================
// One-shot pulse timer, retriggerable
module relay_pulse (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// Trigger and length
	input  wire logic        start,
	input  wire logic [15:0] length,
	// Pulse out
	output logic             active
);

	logic [15:0] count_q;

	// Load on start, count down to zero
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			count_q <= 16'h0000;
		end else if (start) begin
			count_q <= (length == 16'h0000) ? 16'h0001 : length;
		end else if (count_q != 16'h0000) begin
			count_q <= count_q - 16'h0001;
		end
	end

	assign active = (count_q != 16'h0000);

endmodule

/* rtl/door_relay_io.sv */
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps

module door_relay_io (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Door state machine
	input  wire logic        at_upper,
	input  wire logic        at_lower,
	input  wire logic        at_partial,
	input  wire logic        stopped_exact,
	input  wire logic        moving,
	input  wire logic        move_request,
	input  wire logic        fault_block,
	input  wire logic        stop_block,
	input  wire logic        safety_block,
	// Radio receiver channels
	input  wire logic [2:0]  radio_ch,
	// Input terminals
	input  wire logic [2:0]  general_input_function,
	// Relay contacts
	output logic [2:0]       relay_out,
	// Decoded commands
	output logic             move_enable,
	output logic             cmd_impulse,
	output logic             cmd_open,
	output logic             cmd_partial,
	output logic             cmd_close,
	output logic             cmd_stop,
	output logic             smoke_alarm,
	output logic             lock_released
);

	// ==========================================================
	// Configuration registers
	logic [31:0] relay_cfg_q [door_io_pkg::NUM_RELAY];
	logic [31:0] input_cfg_q;
	logic        partial_en_q;
	logic [15:0] pulse_len_q;
	logic [15:0] lock_delay_q;

	logic wr_en;
	assign wr_en = psel & penable & pwrite;

	// Software writes, only on the access phase
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			for (int i = 0; i < door_io_pkg::NUM_RELAY; i++) begin
				relay_cfg_q[i] <= door_io_pkg::RELAY_CFG_RST;
			end
			input_cfg_q  <= door_io_pkg::INPUT_CFG_RST;
			partial_en_q <= 1'b0;
			pulse_len_q  <= door_io_pkg::PULSE_LEN_RST;
			lock_delay_q <= door_io_pkg::LOCK_DELAY_RST;
		end else if (wr_en) begin
			case (paddr)
				door_io_pkg::REG_RELAY_CFG0: relay_cfg_q[0] <= pwdata;
				door_io_pkg::REG_RELAY_CFG1: relay_cfg_q[1] <= pwdata;
				door_io_pkg::REG_RELAY_CFG2: relay_cfg_q[2] <= pwdata;
				door_io_pkg::REG_INPUT_CFG:  input_cfg_q    <= pwdata;
				door_io_pkg::REG_CONTROL:    partial_en_q   <= pwdata[0];
				door_io_pkg::REG_PULSE_LEN:  pulse_len_q    <= pwdata[15:0];
				door_io_pkg::REG_LOCK_DELAY: lock_delay_q   <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Input synchronisers
	logic [2:0] gin_meta_q;
	logic [2:0] gin_q;
	logic [2:0] radio_meta_q;
	logic [2:0] radio_q;
	logic [2:0] radio_prev_q;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			gin_meta_q   <= 3'h0;
			gin_q        <= 3'h0;
			radio_meta_q <= 3'h0;
			radio_q      <= 3'h0;
			radio_prev_q <= 3'h0;
		end else begin
			gin_meta_q   <= general_input_function;
			gin_q        <= gin_meta_q;
			radio_meta_q <= radio_ch;
			radio_q      <= radio_meta_q;
			radio_prev_q <= radio_q;
		end
	end

	logic [2:0] radio_rise;
	assign radio_rise = radio_q & ~radio_prev_q;

	// ==========================================================
	// Door event detection
	logic upper_eff;
	logic upper_prev_q;
	logic lower_prev_q;
	logic moving_prev_q;
	logic req_prev_q;

	assign upper_eff = at_upper | (partial_en_q & at_partial);

	// Edge history of door state
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			upper_prev_q  <= 1'b0;
			lower_prev_q  <= 1'b0;
			moving_prev_q <= 1'b0;
			req_prev_q    <= 1'b0;
		end else begin
			upper_prev_q  <= upper_eff;
			lower_prev_q  <= at_lower;
			moving_prev_q <= moving;
			req_prev_q    <= move_request;
		end
	end

	logic upper_rise;
	logic lower_rise;
	logic req_rise;
	assign upper_rise = upper_eff & ~upper_prev_q;
	assign lower_rise = at_lower & ~lower_prev_q;
	assign req_rise   = move_request & ~req_prev_q;

	// ==========================================================
	// Lock delay: hold movement until delay has run out
	logic [15:0] delay_cnt_q;
	logic        delay_run_q;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			delay_cnt_q <= 16'h0000;
			delay_run_q <= 1'b0;
		end else if (!move_request) begin
			delay_cnt_q <= 16'h0000;
			delay_run_q <= 1'b0;
		end else if (req_rise) begin
			delay_cnt_q <= lock_delay_q;
			delay_run_q <= (lock_delay_q != 16'h0000);
		end else if (delay_cnt_q > 16'h0001) begin
			delay_cnt_q <= delay_cnt_q - 16'h0001;
		end else begin
			delay_cnt_q <= 16'h0000;
			delay_run_q <= 1'b0;
		end
	end

	// Movement released only once the delay is over
	assign move_enable = move_request & ~req_rise & ~delay_run_q;

	// ==========================================================
	// Per-relay function logic
	logic [2:0] relay_d;
	logic [2:0] relay_q;
	logic [2:0] toggle_q;
	logic [2:0] pulse_start;
	logic [2:0] pulse_on;

	for (genvar r = 0; r < door_io_pkg::NUM_RELAY; r++) begin : g_relay
		logic [3:0] func;
		logic [3:0] sel;
		logic [1:0] behav;
		logic       ep_level;
		logic       ep_event;
		assign func  = relay_cfg_q[r][door_io_pkg::FUNC_LSB +: 4];
		assign sel   = relay_cfg_q[r][door_io_pkg::SEL_LSB +: 4];
		assign behav = relay_cfg_q[r][door_io_pkg::BEHAV_LSB +: 2];

		always_comb begin
			ep_level = 1'b0;
			ep_event = 1'b0;
			case (sel)
				door_io_pkg::EP_OPEN: begin
					ep_level = upper_eff;
					ep_event = upper_rise;
				end
				door_io_pkg::EP_CLOSED: begin
					ep_level = at_lower;
					ep_event = lower_rise;
				end
				door_io_pkg::EP_BOTH: begin
					ep_level = upper_eff | at_lower;
					ep_event = upper_rise | lower_rise;
				end
				door_io_pkg::EP_NOT_OPEN:   ep_level = ~upper_eff;
				door_io_pkg::EP_NOT_CLOSED: ep_level = ~at_lower;
				door_io_pkg::EP_NOT_ANY:    ep_level = ~(upper_eff | at_lower);
				default: ;
			endcase
		end

		// Pulse triggers for every pulse-type function
		always_comb begin
			pulse_start[r] = 1'b0;
			case (func)
				door_io_pkg::RF_END:
					pulse_start[r] = ep_event && (behav == door_io_pkg::BH_PULSE);
				door_io_pkg::RF_LOCK:
					case (sel)
						door_io_pkg::LK_OPEN:  pulse_start[r] = req_rise;
						door_io_pkg::LK_CLOSE: pulse_start[r] = lower_rise & stopped_exact;
						default: ;
					endcase
				door_io_pkg::RF_RADIO:
					pulse_start[r] = (sel >= 4'h1) && (sel <= 4'h3) &&
						radio_rise[sel[1:0] - 2'h1] && (behav == door_io_pkg::BH_PERM);
				default: ;
			endcase
		end

		relay_pulse u_pulse (
			.clock   (clock),
			.sys_rst (sys_rst),
			.start   (pulse_start[r]),
			.length  (pulse_len_q),
			.active  (pulse_on[r])
		);

		always_ff @(posedge clock) begin
			if (sys_rst) begin
				toggle_q[r] <= 1'b0;
			end else if (func != door_io_pkg::RF_RADIO) begin
				toggle_q[r] <= 1'b0;
			end else if ((behav == door_io_pkg::BH_TOGGLE) && (sel >= 4'h1) && (sel <= 4'h3) &&
				radio_rise[sel[1:0] - 2'h1]) begin
				toggle_q[r] <= ~toggle_q[r];
			end
		end

		// Relay next state by function
		always_comb begin
			relay_d[r] = 1'b0;
			case (func)
				door_io_pkg::RF_OFF: relay_d[r] = 1'b0;
				// hold or pulse for selections 1-3
				door_io_pkg::RF_END:
					if (sel <= door_io_pkg::EP_BOTH && behav == door_io_pkg::BH_PULSE) begin
						relay_d[r] = pulse_on[r];
					end else begin
						relay_d[r] = ep_level;
					end
				door_io_pkg::RF_LOCK:
					relay_d[r] = (sel == door_io_pkg::LK_PERM) ? moving : pulse_on[r];
				door_io_pkg::RF_RADIO:
					relay_d[r] = (behav == door_io_pkg::BH_TOGGLE) ? toggle_q[r] : pulse_on[r];
				door_io_pkg::RF_FAULT: relay_d[r] = fault_block;
				door_io_pkg::RF_BRAKE: relay_d[r] = moving;
				default: relay_d[r] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			relay_q <= 3'h0;
		end else begin
			relay_q <= relay_d;
		end
	end
	assign relay_out = relay_q;

	// ==========================================================
	// General input decode
	logic [7:0] cmd_d;
	logic [7:0] cmd_q;

	always_comb begin
		cmd_d = 8'h00;
		for (int i = 0; i < door_io_pkg::NUM_INPUT; i++) begin
			if (gin_q[i]) begin
				case (input_cfg_q[4*i +: 4])
					door_io_pkg::IN_IMPULSE: cmd_d[0] = 1'b1;
					door_io_pkg::IN_OPEN:    cmd_d[1] = 1'b1;
					door_io_pkg::IN_PARTIAL: cmd_d[2] = 1'b1;
					door_io_pkg::IN_CLOSE:   cmd_d[3] = 1'b1;
					door_io_pkg::IN_STOP:    cmd_d[4] = 1'b1;
					door_io_pkg::IN_SMOKE:   cmd_d[5] = 1'b1;
					door_io_pkg::IN_LOCKREL: cmd_d[6] = 1'b1;
					default: ;
				endcase
			end
		end
	end

	// Registered command levels
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cmd_q <= 8'h00;
		end else begin
			cmd_q <= cmd_d;
		end
	end

	assign cmd_impulse   = cmd_q[0];
	assign cmd_open      = cmd_q[1];
	assign cmd_partial   = cmd_q[2];
	assign cmd_close     = cmd_q[3];
	assign cmd_stop      = cmd_q[4];
	assign smoke_alarm   = cmd_q[5];
	assign lock_released = cmd_q[6];

	// ==========================================================
	// APB read, zero-wait
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;

	// Read mux
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (paddr)
			door_io_pkg::REG_RELAY_CFG0: rdata_d = relay_cfg_q[0];
			door_io_pkg::REG_RELAY_CFG1: rdata_d = relay_cfg_q[1];
			door_io_pkg::REG_RELAY_CFG2: rdata_d = relay_cfg_q[2];
			door_io_pkg::REG_INPUT_CFG:  rdata_d = input_cfg_q;
			door_io_pkg::REG_CONTROL:    rdata_d = {31'h0, partial_en_q};
			door_io_pkg::REG_PULSE_LEN:  rdata_d = {16'h0, pulse_len_q};
			door_io_pkg::REG_STATUS:     rdata_d = {21'h0, cmd_q[6:0], gin_q, 1'b0} | {29'h0, relay_q};
			door_io_pkg::REG_LOCK_DELAY: rdata_d = {16'h0, lock_delay_q};
			default: ;
		endcase
	end

	// Read data captured in setup cycle
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			rdata_q <= rdata_d;
		end
	end

	assign pready  = 1'b1;
	assign prdata  = rdata_q;
	assign pslverr = 1'b0;

	// ==========================================================
	// Checks
	brake_move_a: assert property (@(posedge clock) disable iff (sys_rst)
		(relay_cfg_q[0][3:0] == door_io_pkg::RF_BRAKE) && $stable(relay_cfg_q[0]) |=> relay_out[0] == $past(moving))
		else $error("brake relay not following movement");
	off_relay_a: assert property (@(posedge clock) disable iff (sys_rst)
		(relay_cfg_q[1][3:0] == door_io_pkg::RF_OFF) |=> !relay_out[1])
		else $error("off relay driven");
	fault_ind_a: assert property (@(posedge clock) disable iff (sys_rst)
		(relay_cfg_q[2][3:0] == door_io_pkg::RF_FAULT) && $stable(relay_cfg_q[2]) |=> relay_out[2] == $past(fault_block))
		else $error("fault relay wrong");
	lock_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
		req_rise && (lock_delay_q == 16'h0006) |=> !move_enable [*6] ##1 (move_enable || !move_request))
		else $error("movement not held for the lock delay");
	sync_in_a: assert property (@(posedge clock) disable iff (sys_rst)
		gin_q == $past(general_input_function, 2))
		else $error("input sync depth wrong");
	pulse_end_a: assert property (@(posedge clock) disable iff (sys_rst)
		pulse_start[0] && pulse_len_q == 16'h0004 |=> pulse_on[0] [*4] ##1 (!pulse_on[0] || $past(pulse_start[0])))
		else $error("pulse length wrong");
	partial_up_a: assert property (@(posedge clock) disable iff (sys_rst)
		(relay_cfg_q[0][9:0] == {door_io_pkg::BH_PERM, door_io_pkg::EP_OPEN, door_io_pkg::RF_END}) &&
		partial_en_q && at_partial |=> relay_out[0])
		else $error("partial not upper");
	stop_cmd_a: assert property (@(posedge clock) disable iff (sys_rst)
		gin_q[0] && input_cfg_q[3:0] == door_io_pkg::IN_STOP |=> cmd_stop)
		else $error("stop command missing");
	cv_pulse: cover property (@(posedge clock) pulse_start[0] ##1 pulse_on[0]);
	cv_toggle: cover property (@(posedge clock) $rose(toggle_q[0]));
	cv_delay: cover property (@(posedge clock) delay_run_q ##1 move_enable);

endmodule

/* tb/door_button_model.sv */
`timescale 1ns/1ps

// ==========================================================
// Push buttons and radio receiver channels
module door_button_model (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       sys_rst,
	// Presses requested by the bench
	input  wire logic [2:0] press_radio,
	input  wire logic [2:0] press_key,
	// Terminal levels
	output logic      [2:0] radio_ch,
	output logic      [2:0] general_input_function
);
	// Contacts settle a cycle after a press; all open during reset
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			radio_ch               <= 3'h0;
			general_input_function <= 3'h0;
		end else begin
			radio_ch               <= press_radio;
			general_input_function <= press_key;
		end
	end
endmodule

/* tb/door_relay_and_input_function_logic_bench.sv */
`timescale 1ns/1ps

module door_relay_and_input_function_logic_bench;
	logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        at_upper, at_lower, at_partial, stopped_exact, moving, move_request;
	logic        fault_block, stop_block, safety_block, move_enable;
	logic [2:0]  radio_ch, general_input_function, relay_out, press_radio, press_key;
	logic        cmd_impulse, cmd_open, cmd_partial, cmd_close, cmd_stop, smoke_alarm, lock_released;
	logic [6:0]  cmds;
	int          bad_count, tests_run, i;
	// Rows: relay config, {upper, lower, moving, fault, stop}, relay expected
	logic [17:0] rows [20] = '{
		{12'h113, 5'h10, 1'h1}, {12'h113, 5'h08, 1'h0}, {12'h123, 5'h08, 1'h1}, {12'h123, 5'h10, 1'h0},
		{12'h133, 5'h10, 1'h1}, {12'h133, 5'h04, 1'h0}, {12'h143, 5'h10, 1'h0}, {12'h143, 5'h08, 1'h1},
		{12'h153, 5'h08, 1'h0}, {12'h153, 5'h10, 1'h1}, {12'h163, 5'h04, 1'h1}, {12'h163, 5'h08, 1'h0},
		{12'h001, 5'h16, 1'h0}, {12'h014, 5'h04, 1'h1}, {12'h014, 5'h10, 1'h0}, {12'h007, 5'h04, 1'h1},
		{12'h007, 5'h08, 1'h0}, {12'h006, 5'h02, 1'h1}, {12'h006, 5'h01, 1'h0}, {12'h243, 5'h08, 1'h1}};

	assign cmds = {cmd_impulse, cmd_open, cmd_partial, cmd_close, cmd_stop, smoke_alarm, lock_released};

	// ==========================================================
	// Design and far side
	door_relay_io dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.at_upper(at_upper), .at_lower(at_lower), .at_partial(at_partial), .stopped_exact(stopped_exact),
		.moving(moving), .move_request(move_request), .fault_block(fault_block), .stop_block(stop_block),
		.safety_block(safety_block), .radio_ch(radio_ch), .general_input_function(general_input_function),
		.relay_out(relay_out), .move_enable(move_enable), .cmd_impulse(cmd_impulse), .cmd_open(cmd_open),
		.cmd_partial(cmd_partial), .cmd_close(cmd_close), .cmd_stop(cmd_stop), .smoke_alarm(smoke_alarm),
		.lock_released(lock_released));
	door_button_model far (.clock(clock), .sys_rst(sys_rst), .press_radio(press_radio), .press_key(press_key),
		.radio_ch(radio_ch), .general_input_function(general_input_function));

	// ==========================================================
	// Helpers
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer; waits on pready, only the watchdog ends a stuck wait
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'h1;
		do begin
			@(posedge clock);
		end while (pready !== 1'h1);
		rd = prdata;
		check("pslverr", pslverr, 32'h0);
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask

	// Lands between edges so registered outputs have settled
	task step(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask

	// Radio press held two cycles so the synchroniser sees it
	task radio(input logic [2:0] m);
		@(posedge clock);
		press_radio <= m;
		repeat (2) @(posedge clock);
		press_radio <= 3'h0;
	endtask

	task test_done;
		$display("Counts: %0d checks, %0d mismatches", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Clock and watchdog
	initial begin
		clock = 1'h0;
		forever #12.5 clock = ~clock;
	end

	// Run needs about 460 cycles; this margin catches a hung wait
	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		test_done();
	end

	// ==========================================================
	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{at_upper, at_lower, at_partial, stopped_exact, moving, move_request} = '0;
		{fault_block, stop_block, safety_block, press_radio, press_key} = '0;
		bad_count = 0;
		tests_run = 0;
		sys_rst = 1'h1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'h0;
		step(0);
		check("relay_out", relay_out, 32'h0);
		apb(1'h0, door_io_pkg::REG_RELAY_CFG0, 32'h0);
		check("relay_cfg0", rd, door_io_pkg::RELAY_CFG_RST);
		apb(1'h0, door_io_pkg::REG_INPUT_CFG, 32'h0);
		check("input_cfg", rd, door_io_pkg::INPUT_CFG_RST);
		apb(1'h0, door_io_pkg::REG_PULSE_LEN, 32'h0);
		check("pulse_len", rd, {16'h0, door_io_pkg::PULSE_LEN_RST});
		apb(1'h1, 8'h40, 32'hFFFF_FFFF);
		apb(1'h0, 8'h40, 32'h0);
		check("unmapped", rd, 32'h0);
		@(posedge clock);
		press_key <= 3'h4;
		step(6);
		check("default stop key", cmd_stop, 32'h1);
		@(posedge clock);
		press_key <= 3'h0;
		$display("Test reset values done");

		apb(1'h1, door_io_pkg::REG_PULSE_LEN, 32'h0000_0004);
		apb(1'h1, door_io_pkg::REG_RELAY_CFG2, 32'h0000_0006);
		for (i = 0; i < 20; i++) begin
			apb(1'h1, door_io_pkg::REG_RELAY_CFG0, {20'h0, rows[i][17:6]});
			@(posedge clock);
			{at_upper, at_lower, moving, fault_block, stop_block} <= rows[i][5:1];
			safety_block <= rows[i][1];
			step(4);
			check("relay row", relay_out[0], rows[i][0]);
			check("off relay", relay_out[1], 32'h0);
			check("fault relay", relay_out[2], rows[i][2]);
		end
		@(posedge clock);
		{at_upper, at_lower, moving, fault_block, stop_block, safety_block} <= '0;
		$display("Test function rows done");

		apb(1'h1, door_io_pkg::REG_RELAY_CFG0, 32'h0000_0213);
		@(posedge clock);
		at_upper <= 1'h1;
		step(4);
		check("end pulse on", relay_out[0], 32'h1);
		step(8);
		check("end pulse off", relay_out[0], 32'h0);
		@(posedge clock);
		at_upper <= 1'h0;
		apb(1'h1, door_io_pkg::REG_CONTROL, 32'h0000_0001);
		apb(1'h1, door_io_pkg::REG_RELAY_CFG0, 32'h0000_0113);
		@(posedge clock);
		at_partial <= 1'h1;
		step(4);
		check("partial on", relay_out[0], 32'h1);
		apb(1'h1, door_io_pkg::REG_CONTROL, 32'h0);
		step(4);
		check("partial off", relay_out[0], 32'h0);
		@(posedge clock);
		at_partial <= 1'h0;
		$display("Test endposition done");

		apb(1'h1, door_io_pkg::REG_RELAY_CFG0, 32'h0000_0125);
		radio(3'h1);
		step(4);
		check("other channel", relay_out[0], 32'h0);
		radio(3'h2);
		step(4);
		check("radio pulse on", relay_out[0], 32'h1);
		step(8);
		check("radio pulse off", relay_out[0], 32'h0);
		apb(1'h1, door_io_pkg::REG_RELAY_CFG0, 32'h0000_0225);
		radio(3'h2);
		step(8);
		check("toggle on", relay_out[0], 32'h1);
		radio(3'h2);
		step(8);
		check("toggle off", relay_out[0], 32'h0);
		$display("Test radio done");

		// closing pulse only when stopped exactly
		apb(1'h1, door_io_pkg::REG_RELAY_CFG0, 32'h0000_0034);
		@(posedge clock);
		stopped_exact <= 1'h1;
		at_lower      <= 1'h1;
		step(4);
		check("close pulse on", relay_out[0], 32'h1);
		step(8);
		check("close pulse off", relay_out[0], 32'h0);
		@(posedge clock);
		{at_lower, stopped_exact} <= 2'h0;
		step(2);
		@(posedge clock);
		at_lower <= 1'h1;
		step(4);
		check("inexact stop", relay_out[0], 32'h0);
		@(posedge clock);
		at_lower <= 1'h0;
		// open pulse and lock delay of six cycles
		apb(1'h1, door_io_pkg::REG_LOCK_DELAY, 32'h0000_0006);
		apb(1'h1, door_io_pkg::REG_RELAY_CFG0, 32'h0000_0024);
		@(posedge clock);
		move_request <= 1'h1;
		step(4);
		check("held off", move_enable, 32'h0);
		check("open pulse on", relay_out[0], 32'h1);
		step(8);
		check("released", move_enable, 32'h1);
		check("open pulse off", relay_out[0], 32'h0);
		@(posedge clock);
		move_request <= 1'h0;
		$display("Test lock done");

		// every input code on input one
		for (i = 1; i < 9; i++) begin
			apb(1'h1, door_io_pkg::REG_INPUT_CFG, {24'h0, 4'h1, i[3:0]} | 32'h0000_0100);
			@(posedge clock);
			press_key <= 3'h1;
			step(6);
			check("input cmds", cmds, (i < 2) ? 32'h0 : 32'h40 >> (i - 2));
			@(posedge clock);
			press_key <= 3'h0;
			step(6);
			check("input idle", cmds, 32'h0);
		end
		$display("Test inputs done");

		// Second reset in mid-run restores the pulse length
		@(posedge clock);
		sys_rst <= 1'h1;
		@(posedge clock);
		sys_rst <= 1'h0;
		step(0);
		check("relay_out again", relay_out, 32'h0);
		check("cmds again", cmds, 32'h0);
		apb(1'h0, door_io_pkg::REG_PULSE_LEN, 32'h0);
		check("pulse_len again", rd, {16'h0, door_io_pkg::PULSE_LEN_RST});
		$display("Test second reset done");
		test_done();
	end
endmodule
